/* File: common/pbx_pkg.sv */
package pbx_pkg;
  // Sizes.
  localparam int NUM_MOD = 8;
  localparam int NUM_SVC = 8;
  localparam int MAX_STN = 64;
  localparam int BATCH_MAX = 6;
  localparam int RETRY_MAX = 32;
  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_ERR = 8'h08;
  localparam logic [7:0] OFS_CFG = 8'h20;
  localparam logic [7:0] OFS_RXH = 8'h40;
  localparam logic [7:0] OFS_TXH = 8'h60;
  // Control field positions.
  localparam int CTRL_STATE_LSB = 0;
  localparam int CTRL_BATCH_LSB = 2;
  localparam int CTRL_NMOD_LSB = 5;
  localparam int CTRL_RETRY_LSB = 9;
  // Per-module configuration field positions.
  localparam int CFG_HEAD_LSB = 0;
  localparam int CFG_EXP = 8;
  localparam int CFG_STN_LSB = 9;
  localparam int CFG_LPRI = 16;
  localparam int CFG_RETAIN = 17;
  localparam int CFG_SEP_LSB = 18;
  // Values after reset.
  localparam logic [2:0] BATCH_RST = 3'h1;
  localparam logic [5:0] RETRY_DEF = 6'h05;
  localparam logic [1:0] CPU_STOP = 2'h0;
  // Master module buffer words.
  localparam logic [15:0] BM_STN_ADDR = 16'h0000;
  localparam logic [15:0] BM_FLT_BASE = 16'h0064;
  localparam logic [15:0] BM_RX_BASE = 16'h006E;
  localparam logic [15:0] BM_TX_BASE = 16'h000A;
  localparam logic [15:0] BM_WORDS = 16'h0020;
  // Occupied I/O points.
  localparam logic [5:0] PTS_BASIC = 6'h20;
  localparam logic [5:0] PTS_EXP = 6'h30;
  // Timing.
  localparam int CLK_PERIOD_NS = 10;
  localparam int WAIT_BASE_NS = 300000;
  localparam int WAIT_STN_NS = 200000;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_SVC = 4'h1,
    ST_MSEL = 4'h3,
    ST_MSTN = 4'h2,
    ST_MFLT = 4'h6,
    ST_MRX = 4'h7,
    ST_MRXW = 4'h5,
    ST_MTXR = 4'h4,
    ST_MTX = 4'hC,
    ST_DONE = 4'hD
  } pbx_state_t;
endpackage

/* File: core/pbx_core.sv */
// Our own choices: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
// Function
// - Buffer read returns addressed module word; buffer write stores given word there.
// - Direct device: unit field is head I/O over 16, word field is decimal.
// - Direct access uses the very same path and timing as explicit access.
// - Module data communication requests are serviced only at end of scan.
// - Requests serviced per end of scan are configurable from one to six.
// - Up to eight link masters; a count of zero disables refresh.
// - Link start output of each configured master is driven by hardware.
// - Refresh runs as one batch after scan end, only when not stopped.
// - Link start stays off until run is entered and one scan completes.
// - A master with hardware or ROM error input on is skipped.
// - Station count from configuration in basic mode, from module in expanded.
// - A master occupies 32 points in basic and 48 in expanded mode.
// - Eight points per station, 512 at most, bit heads multiple of 16.
// - Receive from buffer words 110 to 141, send to 10 to 41.
// - Communication errors are retried up to a set count, default five.
// - Under link priority a CPU access to the master being refreshed waits, bounded by the wait limit.
// - Under CPU priority a CPU access goes first with no wait.
// - Faulty station received data is kept or cleared as selected.
// - Only batch areas are refreshed; separate refresh and terminals excluded.
module pbx_core #(
  parameter int NMOD = pbx_pkg::NUM_MOD,
  parameter int NSVC = pbx_pkg::NUM_SVC,
  parameter int WAIT_BASE_CYC = pbx_pkg::WAIT_BASE_NS / pbx_pkg::CLK_PERIOD_NS,
  parameter int WAIT_STN_CYC = pbx_pkg::WAIT_STN_NS / pbx_pkg::CLK_PERIOD_NS
) (
  // Clock and reset.
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // Register bus.
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Scan sequencer.
  input wire logic i_scan_end,
  output logic o_end_done,
  output logic o_first_scan_flag,
  // Buffer instructions.
  input wire logic i_ins_req,
  input wire logic i_ins_write,
  input wire logic i_ins_direct,
  input wire logic [7:0] i_ins_unit,
  input wire logic [19:0] i_ins_addr,
  input wire logic [15:0] i_ins_wdata,
  output logic o_ins_done,
  output logic [15:0] o_ins_rdata,
  // Module data communication requests.
  input wire logic [NSVC-1:0] i_svc_req,
  input wire logic i_svc_done,
  output logic [NSVC-1:0] o_svc_grant,
  // Link master signals.
  input wire logic [NMOD-1:0] i_hw_err,
  input wire logic [NMOD-1:0] i_rom_err,
  output logic [NMOD-1:0] o_link_start,
  output logic [NMOD-1:0] o_access_priority_select,
  output logic [NMOD-1:0] o_faulty_station_clear_select,
  // Module buffer memory port.
  output logic o_bm_req,
  output logic o_bm_we,
  output logic [11:0] o_bm_head,
  output logic [15:0] o_bm_addr,
  output logic [15:0] o_bm_wdata,
  input wire logic i_bm_ack,
  input wire logic i_bm_err,
  input wire logic [15:0] i_bm_rdata,
  // CPU device memory port.
  output logic o_dev_req,
  output logic o_dev_we,
  output logic [1:0] o_dev_be,
  output logic [15:0] o_dev_addr,
  output logic [15:0] o_dev_wdata,
  input wire logic i_dev_ack,
  input wire logic [15:0] i_dev_rdata
);
  typedef struct packed {
    pbx_pkg::pbx_state_t st;
    logic [1:0] cpu_st;
    logic [2:0] batch;
    logic [3:0] nmod;
    logic [5:0] retry;
    logic [NMOD-1:0][23:0] cfg;
    logic [NMOD-1:0][15:0] rxh;
    logic [NMOD-1:0][15:0] txh;
    logic [NMOD-1:0] comm_err;
    logic [NMOD-1:0] cfg_err;
    logic started;
    logic [3:0] mod;
    logic [5:0] w;
    logic [5:0] nw;
    logic [5:0] rtry;
    logic [15:0] flt;
    logic [15:0] dat;
    logic [NSVC-1:0] gnt;
    logic [2:0] svc_cnt;
    logic bm_req;
    logic bm_we;
    logic bm_own;
    logic [11:0] bm_head;
    logic [15:0] bm_addr;
    logic [15:0] bm_wdata;
    logic dev_req;
    logic dev_we;
    logic [1:0] dev_be;
    logic [15:0] dev_addr;
    logic [15:0] dev_wdata;
    logic ins_done;
    logic [15:0] ins_rdata;
    logic [23:0] wcnt;
    logic end_done;
    logic av_ack;
    logic [31:0] av_rdata;
  } pbx_regs_t;

  pbx_regs_t r;
  pbx_regs_t n;

  function automatic logic [15:0] pbx_bcd(input logic [19:0] b);
    logic [19:0] acc;
    acc = 20'h0;
    for (int i = 4; i >= 0; i--) begin
      acc = 20'(acc * 20'd10 + {16'h0, b[i*4 +: 4]});
    end
    return acc[15:0];
  endfunction

  function automatic logic [5:0] pbx_words(input logic [15:0] s);
    logic [15:0] c;
    c = (s > 16'(pbx_pkg::MAX_STN)) ? 16'(pbx_pkg::MAX_STN) : s;
    return 6'((c + 16'h1) >> 1);
  endfunction

  function automatic logic [5:0] pbx_pts(input logic expanded);
    return expanded ? pbx_pkg::PTS_EXP : pbx_pkg::PTS_BASIC;
  endfunction

  logic running;
  logic [2:0] cur;
  logic [23:0] ccfg;
  logic [2:0] ai;
  logic [31:0] rd;
  logic [15:0] wd_lo;
  logic [11:0] ins_head;
  logic [15:0] ins_addr;
  logic eng_act;
  logic eng_bm;
  logic tgt_hit;
  logic [23:0] wait_lim;
  logic cpu_wait;
  logic cpu_go;
  logic eng_fin;
  logic eng_ok;
  logic dev_fin;
  logic head_bad;
  logic f0;
  logic f1;

  assign running = r.cpu_st != pbx_pkg::CPU_STOP;
  assign cur = r.mod[2:0];
  assign ccfg = r.cfg[cur];
  assign ai = i_avs_address[4:2];
  assign wd_lo = i_avs_writedata[15:0];
  assign ins_head = {i_ins_unit, 4'h0};
  assign ins_addr = i_ins_direct ? pbx_bcd(i_ins_addr) : i_ins_addr[15:0];
  assign eng_act = r.st inside {pbx_pkg::ST_MSTN, pbx_pkg::ST_MFLT, pbx_pkg::ST_MRX,
                                pbx_pkg::ST_MRXW, pbx_pkg::ST_MTXR, pbx_pkg::ST_MTX};
  assign eng_bm = r.st inside {pbx_pkg::ST_MSTN, pbx_pkg::ST_MFLT, pbx_pkg::ST_MRX,
                               pbx_pkg::ST_MTX};
  assign tgt_hit = ins_head == {ccfg[pbx_pkg::CFG_HEAD_LSB +: 8], 4'h0};
  assign wait_lim = 24'(WAIT_BASE_CYC + WAIT_STN_CYC * int'(ccfg[pbx_pkg::CFG_SEP_LSB +: 6]));
  assign cpu_wait = eng_act && ccfg[pbx_pkg::CFG_LPRI] && tgt_hit && (r.wcnt < wait_lim);
  assign cpu_go = i_ins_req && !r.ins_done && !r.bm_req && !cpu_wait;
  assign eng_fin = r.bm_req && i_bm_ack && !r.bm_own;
  assign eng_ok = eng_fin && !i_bm_err;
  assign dev_fin = r.dev_req && i_dev_ack;
  assign head_bad = (r.rxh[cur][3:0] != 4'h0) || (r.txh[cur][3:0] != 4'h0);
  assign f0 = r.flt[{r.w[2:0], 1'b0}];
  assign f1 = r.flt[{r.w[2:0], 1'b1}];

  always_comb begin
    rd = 32'h0;
    if (i_avs_address == pbx_pkg::OFS_CTRL) begin
      rd = {17'h0, r.retry, r.nmod, r.batch, r.cpu_st};
    end else if (i_avs_address == pbx_pkg::OFS_STAT) begin
      rd = {18'h0, r.st != pbx_pkg::ST_IDLE, r.started, r.st, 8'(o_link_start)};
    end else if (i_avs_address == pbx_pkg::OFS_ERR) begin
      rd = {8'h0, 8'(i_hw_err | i_rom_err), 8'(r.cfg_err), 8'(r.comm_err)};
    end else if (i_avs_address[7:5] == pbx_pkg::OFS_CFG[7:5]) begin
      rd = {pbx_pts(r.cfg[ai][pbx_pkg::CFG_EXP]), 2'h0, r.cfg[ai]};
    end else if (i_avs_address[7:5] == pbx_pkg::OFS_RXH[7:5]) begin
      rd = {16'h0, r.rxh[ai]};
    end else if (i_avs_address[7:5] == pbx_pkg::OFS_TXH[7:5]) begin
      rd = {16'h0, r.txh[ai]};
    end
  end

  always_comb begin
    n = r;
    n.ins_done = 1'b0;
    n.end_done = 1'b0;
    n.av_ack = (i_avs_read || i_avs_write) && !r.av_ack;
    if (n.av_ack) begin
      n.av_rdata = rd;
    end
    if (r.av_ack && i_avs_write) begin
      if (i_avs_address == pbx_pkg::OFS_CTRL) begin
        n.cpu_st = i_avs_writedata[pbx_pkg::CTRL_STATE_LSB +: 2];
        n.batch = i_avs_writedata[pbx_pkg::CTRL_BATCH_LSB +: 3];
        if (n.batch == 3'h0) begin
          n.batch = 3'h1;
        end else if (n.batch > 3'(pbx_pkg::BATCH_MAX)) begin
          n.batch = 3'(pbx_pkg::BATCH_MAX);
        end
        n.nmod = i_avs_writedata[pbx_pkg::CTRL_NMOD_LSB +: 4];
        if (n.nmod > 4'(NMOD)) begin
          n.nmod = 4'(NMOD);
        end
        n.retry = i_avs_writedata[pbx_pkg::CTRL_RETRY_LSB +: 6];
        if (n.retry > 6'(pbx_pkg::RETRY_MAX)) begin
          n.retry = 6'(pbx_pkg::RETRY_MAX);
        end
      end else if (i_avs_address == pbx_pkg::OFS_ERR) begin
        n.comm_err = r.comm_err & ~NMOD'(i_avs_writedata[7:0]);
        n.cfg_err = r.cfg_err & ~NMOD'(i_avs_writedata[15:8]);
      end else if (i_avs_address[7:5] == pbx_pkg::OFS_CFG[7:5]) begin
        n.cfg[ai] = i_avs_writedata[23:0];
      end else if (i_avs_address[7:5] == pbx_pkg::OFS_RXH[7:5]) begin
        n.rxh[ai] = wd_lo;
      end else if (i_avs_address[7:5] == pbx_pkg::OFS_TXH[7:5]) begin
        n.txh[ai] = wd_lo;
      end
    end
    unique case (r.st)
      pbx_pkg::ST_IDLE: begin
        if (i_scan_end) begin
          n.st = pbx_pkg::ST_SVC;
          n.svc_cnt = 3'h0;
        end
      end
      pbx_pkg::ST_SVC: begin
        if (r.gnt != '0) begin
          if (i_svc_done) begin
            n.gnt = '0;
            n.svc_cnt = r.svc_cnt + 3'h1;
          end
        end else if (r.svc_cnt < r.batch && i_svc_req != '0) begin
          n.gnt = i_svc_req & (~i_svc_req + NSVC'(1));
        end else begin
          n.st = pbx_pkg::ST_MSEL;
          n.mod = 4'h0;
        end
      end
      pbx_pkg::ST_MSEL: begin
        if (!running || r.mod >= r.nmod) begin
          n.st = pbx_pkg::ST_DONE;
        end else if (i_hw_err[cur] || i_rom_err[cur] || head_bad) begin
          n.cfg_err[cur] = n.cfg_err[cur] | head_bad;
          n.mod = r.mod + 4'h1;
        end else begin
          n.w = 6'h0;
          n.rtry = 6'h0;
          if (ccfg[pbx_pkg::CFG_EXP]) begin
            n.st = pbx_pkg::ST_MSTN;
          end else begin
            n.nw = pbx_words({9'h0, ccfg[pbx_pkg::CFG_STN_LSB +: 7]});
            if (n.nw == 6'h0) begin
              n.mod = r.mod + 4'h1;
            end else begin
              n.st = pbx_pkg::ST_MFLT;
            end
          end
        end
      end
      pbx_pkg::ST_MSTN: begin
        if (eng_ok) begin
          n.nw = pbx_words(i_bm_rdata);
          if (n.nw == 6'h0) begin
            n.mod = r.mod + 4'h1;
            n.st = pbx_pkg::ST_MSEL;
          end else begin
            n.st = pbx_pkg::ST_MFLT;
          end
        end
      end
      pbx_pkg::ST_MFLT: begin
        if (eng_ok) begin
          n.flt = i_bm_rdata;
          n.st = pbx_pkg::ST_MRX;
        end
      end
      pbx_pkg::ST_MRX: begin
        if (eng_ok) begin
          if (ccfg[pbx_pkg::CFG_RETAIN]) begin
            n.dat = i_bm_rdata;
            n.dev_be = {~f1, ~f0};
          end else begin
            n.dat = {f1 ? 8'h00 : i_bm_rdata[15:8], f0 ? 8'h00 : i_bm_rdata[7:0]};
            n.dev_be = 2'h3;
          end
          n.st = pbx_pkg::ST_MRXW;
        end
      end
      pbx_pkg::ST_MRXW: begin
        if (dev_fin) begin
          n.st = pbx_pkg::ST_MTXR;
        end
      end
      pbx_pkg::ST_MTXR: begin
        if (dev_fin) begin
          n.dat = i_dev_rdata;
          n.st = pbx_pkg::ST_MTX;
        end
      end
      pbx_pkg::ST_MTX: begin
        if (eng_ok) begin
          n.w = r.w + 6'h1;
          if (n.w == r.nw) begin
            n.mod = r.mod + 4'h1;
            n.st = pbx_pkg::ST_MSEL;
          end else if (n.w[2:0] == 3'h0) begin
            n.st = pbx_pkg::ST_MFLT;
          end else begin
            n.st = pbx_pkg::ST_MRX;
          end
        end
      end
      pbx_pkg::ST_DONE: begin
        n.end_done = 1'b1;
        n.started = running;
        n.st = pbx_pkg::ST_IDLE;
      end
      default: begin
        n.st = pbx_pkg::ST_IDLE;
      end
    endcase
    if (eng_ok) begin
      n.rtry = 6'h0;
    end else if (eng_fin) begin
      if (r.rtry < r.retry) begin
        n.rtry = r.rtry + 6'h1;
      end else begin
        n.comm_err[cur] = 1'b1;
        n.mod = r.mod + 4'h1;
        n.st = pbx_pkg::ST_MSEL;
      end
    end
    if (!running) begin
      n.started = 1'b0;
    end
    if (r.bm_req && i_bm_ack) begin
      n.bm_req = 1'b0;
      if (r.bm_own) begin
        n.ins_done = 1'b1;
        n.ins_rdata = i_bm_rdata;
      end
    end else if (cpu_go) begin
      n.bm_req = 1'b1;
      n.bm_own = 1'b1;
      n.bm_we = i_ins_write;
      n.bm_head = ins_head;
      n.bm_addr = ins_addr;
      n.bm_wdata = i_ins_wdata;
    end else if (eng_bm && !r.bm_req) begin
      n.bm_req = 1'b1;
      n.bm_own = 1'b0;
      n.bm_we = r.st == pbx_pkg::ST_MTX;
      n.bm_head = {ccfg[pbx_pkg::CFG_HEAD_LSB +: 8], 4'h0};
      n.bm_wdata = r.dat;
      unique case (r.st)
        pbx_pkg::ST_MSTN: n.bm_addr = pbx_pkg::BM_STN_ADDR;
        pbx_pkg::ST_MFLT: n.bm_addr = pbx_pkg::BM_FLT_BASE + {13'h0, r.w[5:3]};
        pbx_pkg::ST_MRX: n.bm_addr = pbx_pkg::BM_RX_BASE + {10'h0, r.w};
        default: n.bm_addr = pbx_pkg::BM_TX_BASE + {10'h0, r.w};
      endcase
    end
    if (i_ins_req && cpu_wait) begin
      n.wcnt = r.wcnt + 24'h1;
    end else begin
      n.wcnt = 24'h0;
    end
    if (dev_fin) begin
      n.dev_req = 1'b0;
    end else if (!r.dev_req && (r.st == pbx_pkg::ST_MRXW || r.st == pbx_pkg::ST_MTXR)) begin
      n.dev_req = 1'b1;
      n.dev_we = r.st == pbx_pkg::ST_MRXW;
      n.dev_wdata = r.dat;
      if (r.st == pbx_pkg::ST_MRXW) begin
        n.dev_addr = {4'h0, r.rxh[cur][15:4]} + {10'h0, r.w};
      end else begin
        n.dev_be = 2'h3;
        n.dev_addr = {4'h0, r.txh[cur][15:4]} + {10'h0, r.w};
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      r <= '0;
      r.batch <= pbx_pkg::BATCH_RST;
      r.retry <= pbx_pkg::RETRY_DEF;
    end else begin
      r <= n;
    end
  end

  for (genvar k = 0; k < NMOD; k++) begin : g_mod
    assign o_link_start[k] = r.started && (4'(k) < r.nmod);
    assign o_access_priority_select[k] = r.cfg[k][pbx_pkg::CFG_LPRI];
    assign o_faulty_station_clear_select[k] = !r.cfg[k][pbx_pkg::CFG_RETAIN];
  end

  assign o_avs_readdata = r.av_rdata;
  assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !r.av_ack;
  assign o_end_done = r.end_done;
  assign o_first_scan_flag = running && !r.started;
  assign o_ins_done = r.ins_done;
  assign o_ins_rdata = r.ins_rdata;
  assign o_svc_grant = r.gnt;
  assign o_bm_req = r.bm_req;
  assign o_bm_we = r.bm_we;
  assign o_bm_head = r.bm_head;
  assign o_bm_addr = r.bm_addr;
  assign o_bm_wdata = r.bm_wdata;
  assign o_dev_req = r.dev_req;
  assign o_dev_we = r.dev_we;
  assign o_dev_be = r.dev_be;
  assign o_dev_addr = r.dev_addr;
  assign o_dev_wdata = r.dev_wdata;

  start_gate_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    $rose(r.started) |-> o_end_done) else $error("Link start rose outside end of scan.");
  svc_window_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_svc_grant != '0 |-> r.st == pbx_pkg::ST_SVC) else $error("Grant outside end of scan.");
  batch_cap_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    $rose(r.gnt != '0) |-> $past(r.svc_cnt) < $past(r.batch)) else $error("Batch exceeded.");
  refresh_off_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    r.st == pbx_pkg::ST_MSEL && (r.nmod == 4'h0 || !running) |=> r.st == pbx_pkg::ST_DONE)
    else $error("Refresh ran while disabled.");
  err_skip_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    r.st == pbx_pkg::ST_MSEL && running && r.mod < r.nmod && (i_hw_err[cur] || i_rom_err[cur])
    |=> r.st == pbx_pkg::ST_MSEL && r.mod == $past(r.mod) + 4'h1)
    else $error("Faulty master not skipped.");
  rx_window_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_bm_req && !r.bm_own && r.st == pbx_pkg::ST_MRX |-> !o_bm_we
    && o_bm_addr >= pbx_pkg::BM_RX_BASE && o_bm_addr < pbx_pkg::BM_RX_BASE + pbx_pkg::BM_WORDS)
    else $error("Receive read outside batch area.");
  tx_window_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_bm_req && !r.bm_own && r.st == pbx_pkg::ST_MTX |-> o_bm_we
    && o_bm_addr >= pbx_pkg::BM_TX_BASE && o_bm_addr < pbx_pkg::BM_TX_BASE + pbx_pkg::BM_WORDS)
    else $error("Send write outside batch area.");
  retry_cap_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    eng_fin && i_bm_err && r.rtry >= r.retry |=> r.st == pbx_pkg::ST_MSEL && r.rtry == 6'h0
    || r.comm_err[$past(cur)]) else $error("Retry count exceeded.");
  cpu_first_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_ins_req && !o_ins_done && !o_bm_req && !ccfg[pbx_pkg::CFG_LPRI] |=> o_bm_req && r.bm_own)
    else $error("CPU access delayed under CPU priority.");
  flt_clear_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_dev_req && o_dev_we && !ccfg[pbx_pkg::CFG_RETAIN] |-> o_dev_be == 2'h3)
    else $error("Clear mode wrote partial word.");
endmodule

/* File: tb/pbx_mem_model.sv */
`timescale 1ns/1ps
// Word memory behind a request and acknowledge handshake, used for module buffer and devices.
module pbx_mem_model (
  // Clock and pacing.
  input wire logic i_sys_clk,
  input wire logic [3:0] i_delay,
  // Request side.
  input wire logic i_req,
  input wire logic i_we,
  input wire logic [1:0] i_be,
  input wire logic [15:0] i_addr,
  input wire logic [15:0] i_wdata,
  // Answer side.
  output logic o_ack,
  output logic [15:0] o_rdata
);
  logic [15:0] mem [0:1023];
  logic [3:0] cnt_reg;
  logic [15:0] last_reg;

  initial begin
    o_ack = 1'b0;
    o_rdata = 16'h0000;
    cnt_reg = 4'h0;
    last_reg = 16'h0000;
    for (int i = 0; i < 1024; i++) begin
      mem[i] = 16'h0000;
    end
  end

  // Answers after i_delay idle cycles; read data lines show the inverse of the last word otherwise.
  always @(posedge i_sys_clk) begin
    if (o_ack || !i_req) begin
      o_ack <= 1'b0;
      cnt_reg <= 4'h0;
      o_rdata <= ~last_reg;
    end else if (cnt_reg >= i_delay) begin
      o_ack <= 1'b1;
      o_rdata <= mem[i_addr[9:0]];
      last_reg <= mem[i_addr[9:0]];
      if (i_we && i_be[0]) begin
        mem[i_addr[9:0]][7:0] <= i_wdata[7:0];
      end
      if (i_we && i_be[1]) begin
        mem[i_addr[9:0]][15:8] <= i_wdata[15:8];
      end
    end else begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end
endmodule

/* File: tb/test_pbx_core.sv */
`timescale 1ns/1ps
module test_pbx_core;
  logic i_sys_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [7:0] av_addr = 8'h00;
  logic av_read = 1'b0;
  logic av_write = 1'b0;
  logic [31:0] av_wdata = 32'h00000000;
  logic [31:0] av_rdata;
  logic av_wait;
  logic scan_end = 1'b0;
  logic end_done, first_scan;
  logic ins_req = 1'b0;
  logic ins_we = 1'b0;
  logic ins_dir = 1'b0;
  logic [7:0] ins_unit = 8'h04;
  logic [19:0] ins_addr = 20'h00000;
  logic [15:0] ins_wd = 16'h0000;
  logic ins_done;
  logic [15:0] ins_rdata, q;
  logic [7:0] hw_err = 8'h00, rom_err = 8'h00, svc_req = 8'h00, svc_gnt;
  logic [7:0] g_seen = 8'h00;
  logic svc_done = 1'b0, bm_err = 1'b0;
  int n_gnt = 0;
  logic [7:0] link_start, pri_sel, clr_sel;
  logic bm_req, bm_we, bm_ack, dev_req, dev_we, dev_ack;
  logic [11:0] bm_head;
  logic [15:0] bm_addr, bm_wdata, bm_rdata, dev_addr, dev_wdata, dev_rdata;
  logic [1:0] dev_be;
  logic [31:0] d;
  int err_count = 0;
  int n_compared = 0;
  int cyc = 0;

  always #5 i_sys_clk = ~i_sys_clk;

  pbx_core #(.WAIT_BASE_CYC(20), .WAIT_STN_CYC(10)) u_dut (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_avs_address(av_addr), .i_avs_read(av_read),
    .i_avs_write(av_write), .i_avs_writedata(av_wdata), .o_avs_readdata(av_rdata),
    .o_avs_waitrequest(av_wait), .i_scan_end(scan_end), .o_end_done(end_done),
    .o_first_scan_flag(first_scan), .i_ins_req(ins_req), .i_ins_write(ins_we),
    .i_ins_direct(ins_dir), .i_ins_unit(ins_unit), .i_ins_addr(ins_addr),
    .i_ins_wdata(ins_wd), .o_ins_done(ins_done), .o_ins_rdata(ins_rdata),
    .i_svc_req(svc_req), .i_svc_done(svc_done), .o_svc_grant(svc_gnt), .i_hw_err(hw_err),
    .i_rom_err(rom_err), .o_link_start(link_start), .o_access_priority_select(pri_sel),
    .o_faulty_station_clear_select(clr_sel), .o_bm_req(bm_req), .o_bm_we(bm_we),
    .o_bm_head(bm_head), .o_bm_addr(bm_addr), .o_bm_wdata(bm_wdata), .i_bm_ack(bm_ack),
    .i_bm_err(bm_err), .i_bm_rdata(bm_rdata), .o_dev_req(dev_req), .o_dev_we(dev_we),
    .o_dev_be(dev_be), .o_dev_addr(dev_addr), .o_dev_wdata(dev_wdata),
    .i_dev_ack(dev_ack), .i_dev_rdata(dev_rdata));

  pbx_mem_model u_bm (.i_sys_clk(i_sys_clk), .i_delay(4'h2), .i_req(bm_req), .i_we(bm_we),
    .i_be(2'h3), .i_addr(bm_addr), .i_wdata(bm_wdata), .o_ack(bm_ack), .o_rdata(bm_rdata));
  pbx_mem_model u_dev (.i_sys_clk(i_sys_clk), .i_delay(4'h0), .i_req(dev_req), .i_we(dev_we),
    .i_be(dev_be), .i_addr(dev_addr), .i_wdata(dev_wdata), .o_ack(dev_ack),
    .o_rdata(dev_rdata));

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task stop_test;
    $display("Compared %0d, errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Requesting module: finishes each granted communication one cycle after seeing it.
  always @(posedge i_sys_clk) begin
    svc_done <= svc_gnt != 8'h00 && !svc_done;
    if (svc_gnt != 8'h00 && !svc_done) begin
      n_gnt <= n_gnt + 1;
      g_seen <= g_seen | svc_gnt;
    end
  end

  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      stop_test;
    end
  end

  task av_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge i_sys_clk);
    av_write <= 1'b1;
    av_addr <= a;
    av_wdata <= v;
    do @(posedge i_sys_clk); while (av_wait !== 1'b0);
    av_write <= 1'b0;
    #1;
  endtask

  task av_rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge i_sys_clk);
    av_read <= 1'b1;
    av_addr <= a;
    do @(posedge i_sys_clk); while (av_wait !== 1'b0);
    v = av_rdata;
    av_read <= 1'b0;
  endtask

  task ins(input logic we, input logic dir, input logic [19:0] a, input logic [15:0] v);
    @(posedge i_sys_clk);
    ins_req <= 1'b1;
    ins_we <= we;
    ins_dir <= dir;
    ins_addr <= a;
    ins_wd <= v;
    do @(posedge i_sys_clk); while (ins_done !== 1'b1);
    q = ins_rdata;
    ins_req <= 1'b0;
  endtask

  task scan;
    @(posedge i_sys_clk);
    scan_end <= 1'b1;
    @(posedge i_sys_clk);
    scan_end <= 1'b0;
    do @(posedge i_sys_clk); while (end_done !== 1'b1);
    #1;
  endtask

  // Register defaults, an unmapped read and the occupied point readback.
  task t_regs;
    av_rd(pbx_pkg::OFS_CTRL, d);
    chk(d, 32'h00000A04);
    av_rd(8'h10, d);
    chk(d, 32'h00000000);
    av_rd(pbx_pkg::OFS_CFG, d);
    chk(d, 32'h80000000);
    chk({24'h000000, pri_sel}, 32'h00000000);
    chk({24'h000000, clr_sel}, 32'h000000FF);
    av_wr(pbx_pkg::OFS_CFG, 32'h00000100);
    av_rd(pbx_pkg::OFS_CFG, d);
    chk(d, 32'hC0000100);
  endtask

  // Explicit and direct buffer accesses, including the parameter area before link start.
  task t_ins;
    u_bm.mem[16] = 16'hDEAD;
    ins(1'b1, 1'b0, 20'h0000A, 16'h1234);
    chk({16'h0000, u_bm.mem[10]}, 32'h00001234);
    ins(1'b0, 1'b1, 20'h00010, 16'h0000);
    chk({16'h0000, q}, 32'h00001234);
    chk({20'h00000, bm_head}, 32'h00000040);
    ins(1'b1, 1'b1, 20'h00860, 16'h0BEE);
    chk({16'h0000, u_bm.mem[860]}, 32'h00000BEE);
  endtask

  // Batch refresh with clear, retain, error skip, stop state and zero modules.
  task t_refresh;
    u_bm.mem[110] = 16'hA5C3;
    u_dev.mem[32] = 16'h5A5A;
    av_wr(pbx_pkg::OFS_RXH, 32'h00000100);
    av_wr(pbx_pkg::OFS_TXH, 32'h00000200);
    av_wr(pbx_pkg::OFS_CFG, 32'h00000404);
    av_wr(pbx_pkg::OFS_CTRL, 32'h00000A25);
    chk({24'h000000, link_start}, 32'h00000000);
    chk({31'h00000000, first_scan}, 32'h00000001);
    scan;
    chk({24'h000000, link_start}, 32'h00000001);
    chk({31'h00000000, first_scan}, 32'h00000000);
    chk({16'h0000, u_dev.mem[16]}, 32'h0000A5C3);
    chk({16'h0000, u_bm.mem[10]}, 32'h00005A5A);
    u_bm.mem[100] = 16'h0001;
    u_bm.mem[110] = 16'h1234;
    av_wr(pbx_pkg::OFS_CFG, 32'h00030404);
    chk({24'h000000, clr_sel}, 32'h000000FE);
    chk({24'h000000, pri_sel}, 32'h00000001);
    scan;
    chk({16'h0000, u_dev.mem[16]}, 32'h000012C3);
    av_wr(pbx_pkg::OFS_CFG, 32'h00000404);
    scan;
    chk({16'h0000, u_dev.mem[16]}, 32'h00001200);
    u_bm.mem[100] = 16'h0000;
    u_bm.mem[110] = 16'hFFFF;
    hw_err <= 8'h01;
    scan;
    chk({16'h0000, u_dev.mem[16]}, 32'h00001200);
    hw_err <= 8'h00;
    av_wr(pbx_pkg::OFS_CTRL, 32'h00000A24);
    scan;
    chk({16'h0000, u_dev.mem[16]}, 32'h00001200);
    chk({24'h000000, link_start}, 32'h00000000);
    av_wr(pbx_pkg::OFS_CTRL, 32'h00000A05);
    scan;
    scan;
    chk({24'h000000, link_start}, 32'h00000000);
    chk({16'h0000, u_dev.mem[16]}, 32'h00001200);
  endtask

  // Data communication requests only at end of scan, limited by the batch count.
  task t_svc;
    svc_req <= 8'h0C;
    av_wr(pbx_pkg::OFS_CTRL, 32'h00000A09);
    chk(n_gnt, 0);
    scan;
    chk(n_gnt, 2);
    chk({24'h000000, g_seen}, 32'h00000004);
    svc_req <= 8'h00;
  endtask

  // Module error input, then a communication error that outlasts the retries.
  task t_err;
    rom_err <= 8'h01;
    av_wr(pbx_pkg::OFS_CTRL, 32'h00000225);
    scan;
    chk({16'h0000, u_dev.mem[16]}, 32'h00001200);
    av_rd(pbx_pkg::OFS_ERR, d);
    chk(d, 32'h00010000);
    rom_err <= 8'h00;
    bm_err <= 1'b1;
    scan;
    bm_err <= 1'b0;
    chk({16'h0000, u_dev.mem[16]}, 32'h00001200);
    av_rd(pbx_pkg::OFS_ERR, d);
    chk(d, 32'h00000001);
  endtask

  initial begin
    repeat (20) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    t_regs;
    t_ins;
    t_refresh;
    t_svc;
    t_err;
    stop_test;
  end
endmodule
